// *** design/retirement_event_tagging_pkg.sv ***
package retirement_event_tagging_pkg;

	// Register port geometry
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [5:0] OFF_UPSTREAM = 6'h00;
	localparam logic [5:0] OFF_EXEC = 6'h04;
	localparam logic [5:0] OFF_SAMPLE = 6'h08;
	localparam logic [5:0] OFF_MATRIX = 6'h0C;
	localparam logic [5:0] OFF_LS_SEL0 = 6'h10;
	localparam logic [5:0] OFF_LS_SEL1 = 6'h14;
	localparam logic [5:0] OFF_MOB_SEL = 6'h18;
	localparam logic [5:0] OFF_REPLAY = 6'h1C;
	localparam logic [5:0] OFF_QUAL = 6'h20;
	localparam logic [5:0] OFF_STATUS = 6'h24;
	localparam logic [5:0] OFF_IRQ_MASK = 6'h28;

	// Event select control layout
	localparam int CODE_LSB = 25;
	localparam int CODE_W = 7;
	localparam int MASK_LSB = 9;
	localparam int MASK_W = 16;
	localparam int TAGVAL_LSB = 5;
	localparam int TAGVAL_W = 4;
	localparam int TAG_EN_BIT = 4;
	localparam logic [3:0] TAG_VALUE_COUNTED = 4'h1;

	// Bit positions inside the 16-bit event mask field
	localparam int ALL_UOPS_BIT = 15;
	localparam int PORT0_MOVES_BIT = 3;
	localparam int PORT2_MOVES_BIT = 4;
	localparam int NONSPEC_TAG0_BIT = 0;
	localparam int NONSPEC_BIT = 0;
	localparam int SPLIT_BIT = 1;
	localparam int PARTIAL_FWD_BIT = 4;
	localparam int MISALIGNED_BIT = 5;

	// Sample enable register bits
	localparam int SE_L1_MISS = 0;
	localparam int SE_L2_MISS = 1;
	localparam int SE_DTLB_MISS = 2;
	localparam int SE_ORDER_BUF = 9;
	localparam int SE_SPLIT = 10;
	localparam int SE_COMMON_A = 24;
	localparam int SE_COMMON_B = 25;

	// Replay matrix bits
	localparam int MATRIX_LOAD = 0;
	localparam int MATRIX_STORE = 1;

	// Interrupt status bits
	localparam int ST_W = 3;
	localparam int ST_EXEC = 0;
	localparam int ST_REPLAY = 1;
	localparam int ST_UNTAGGED = 2;
	localparam logic [2:0] ST_RESET = 3'h0;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// Non-retirement events whose mask qualification is reported
	typedef enum logic [2:0] {
		EV_FETCH_REQUEST,
		EV_BUS_ALLOCATION,
		EV_CACHE_REFERENCE,
		EV_MEMORY_CANCEL,
		EV_SIMD_INPUT_ASSIST,
		EV_MEDIA64_UOP,
		EV_PACKED_DOUBLE_UOP,
		EV_NONE
	} qual_event_t;

endpackage

// *** design/mask_qualifier.sv ***
`timescale 1ns/10ps
module mask_qualifier (
	// Query
	input wire retirement_event_tagging_pkg::qual_event_t event_id,
	// Answer: defined mask bits and those that are thread independent
	output logic [15:0] defined_map,
	output logic [15:0] thread_independent
);

	// Fixed classification table of each event's mask bits
	always_comb begin
		defined_map = 16'h0000;
		thread_independent = 16'h0000;
		case (event_id)
			retirement_event_tagging_pkg::EV_FETCH_REQUEST: begin
				defined_map = 16'h0001; // see RULE_08
			end
			retirement_event_tagging_pkg::EV_BUS_ALLOCATION: begin
				defined_map = 16'h3FEF; // see RULE_08
			end
			retirement_event_tagging_pkg::EV_CACHE_REFERENCE: begin
				defined_map = 16'h0FFF; // see RULE_08
			end
			retirement_event_tagging_pkg::EV_MEMORY_CANCEL: begin
				defined_map = 16'h000C; // see RULE_08
			end
			retirement_event_tagging_pkg::EV_SIMD_INPUT_ASSIST,
			retirement_event_tagging_pkg::EV_MEDIA64_UOP,
			retirement_event_tagging_pkg::EV_PACKED_DOUBLE_UOP: begin
				defined_map = 16'h8000;
				thread_independent = 16'h8000; // see RULE_08
			end
			default: begin
				defined_map = 16'h0000;
				thread_independent = 16'h0000;
			end
		endcase
	end

endmodule // mask_qualifier

// *** design/retirement_event_tagging.sv ***
`timescale 1ns/10ps
// How it works
// RULE_01: An execution count needs upstream tag value 1 and the tag-0 mask.
// RULE_02: Software sets all-uops, or both port moves bits, with tag enable.
// RULE_03: Replay counts need sample bits 24 and 25, own bit, nonspec mask.
// RULE_04: Split replays use sample bit 10 and matrix bit 0 or 1 by selector.
// RULE_05: I/O, uncached, locked, return and far uops are never tagged.
// RULE_06: The second-level miss metric counts fast-detected misses only.
// RULE_07: Order-buffer replays count loads not forwarded as aligned subsets.
// RULE_08: Each non-retirement mask bit is reported per-thread or independent.
module retirement_event_tagging (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Retiring uop from the pipeline
	input wire logic uop_retire,
	input wire logic [6:0] uop_event_code,
	input wire logic [15:0] uop_mask_hits,
	input wire logic uop_untaggable,
	input wire logic uop_speculative,
	// Retiring replayed memory uop
	input wire logic replay_retire,
	input wire logic replay_is_load,
	input wire logic replay_is_store,
	input wire logic replay_untaggable,
	input wire logic replay_speculative,
	input wire logic replay_l1_miss,
	input wire logic replay_l2_fast_miss,
	input wire logic replay_l2_late_miss,
	input wire logic replay_dtlb_miss,
	input wire logic replay_fwd_unaligned,
	input wire logic replay_split,
	// Count pulses to the counters and interrupt
	output logic exec_count,
	output logic replay_count,
	output logic irq
);

	logic [31:0] upstream_sel, exec_sel, sample_enable_reg, replay_matrix_reg;
	logic [31:0] load_store_selector_0, load_store_selector_1;
	logic [31:0] mob_sel, replay_sel;
	retirement_event_tagging_pkg::qual_event_t qual_event;
	logic [2:0] status, irq_mask, next_status;
	logic [15:0] qual_defined, qual_indep, up_mask, exec_mask;
	logic [15:0] st_mask, ld_mask, mob_mask, rp_mask;
	logic exec_tag, exec_hit, replay_base, m_load, m_store;
	logic replay_hit, untagged_drop;

	// Event mask field of a selector word
	function automatic logic [15:0] mask_of(input logic [31:0] sel);
		return sel[retirement_event_tagging_pkg::MASK_LSB +:
			retirement_event_tagging_pkg::MASK_W];
	endfunction

	// Register write strobe decode
	function automatic logic wr_hit(input logic [5:0] off);
		return reg_wr && (reg_addr == off);
	endfunction

	assign up_mask = mask_of(upstream_sel);
	assign exec_mask = mask_of(exec_sel);
	assign st_mask = mask_of(load_store_selector_0);
	assign ld_mask = mask_of(load_store_selector_1);
	assign mob_mask = mask_of(mob_sel);
	assign rp_mask = mask_of(replay_sel);

	mask_qualifier u_qual (
		.event_id(qual_event),
		.defined_map(qual_defined),
		.thread_independent(qual_indep)
	);

	// Upstream tagging: selector code and mask must match the uop
	assign exec_tag = uop_retire && !uop_untaggable // see RULE_05
		&& upstream_sel[retirement_event_tagging_pkg::TAG_EN_BIT]
		&& (uop_event_code == upstream_sel[
			retirement_event_tagging_pkg::CODE_LSB +:
			retirement_event_tagging_pkg::CODE_W])
		&& |(uop_mask_hits & up_mask); // see RULE_02

	// Execution event counts tagged, non-speculative uops
	assign exec_hit = exec_tag && !uop_speculative
		&& (upstream_sel[retirement_event_tagging_pkg::TAGVAL_LSB +:
			retirement_event_tagging_pkg::TAGVAL_W]
			== retirement_event_tagging_pkg::TAG_VALUE_COUNTED)
		&& exec_mask[retirement_event_tagging_pkg::NONSPEC_TAG0_BIT]; // see RULE_01

	// Common replay qualification
	assign replay_base = replay_retire && !replay_untaggable // see RULE_05
		&& !replay_speculative
		&& sample_enable_reg[retirement_event_tagging_pkg::SE_COMMON_A]
		&& sample_enable_reg[retirement_event_tagging_pkg::SE_COMMON_B]
		&& rp_mask[retirement_event_tagging_pkg::NONSPEC_BIT]; // see RULE_03
	assign m_load = replay_is_load
		&& replay_matrix_reg[retirement_event_tagging_pkg::MATRIX_LOAD];
	assign m_store = replay_is_store
		&& replay_matrix_reg[retirement_event_tagging_pkg::MATRIX_STORE];

	// Per-metric replay qualification; late misses never count
	assign replay_hit = replay_base && (
		(sample_enable_reg[retirement_event_tagging_pkg::SE_L1_MISS]
			&& replay_l1_miss && m_load)
		|| (sample_enable_reg[retirement_event_tagging_pkg::SE_L2_MISS]
			&& replay_l2_fast_miss && m_load) // see RULE_06
		|| (sample_enable_reg[retirement_event_tagging_pkg::SE_DTLB_MISS]
			&& replay_dtlb_miss && (m_load || m_store))
		|| (sample_enable_reg[retirement_event_tagging_pkg::SE_ORDER_BUF]
			&& replay_fwd_unaligned && m_load
			&& mob_mask[retirement_event_tagging_pkg::PARTIAL_FWD_BIT]
			&& mob_mask[retirement_event_tagging_pkg::MISALIGNED_BIT]) // see RULE_07
		|| (sample_enable_reg[retirement_event_tagging_pkg::SE_SPLIT]
			&& replay_split && m_load
			&& ld_mask[retirement_event_tagging_pkg::SPLIT_BIT]) // see RULE_04
		|| (sample_enable_reg[retirement_event_tagging_pkg::SE_SPLIT]
			&& replay_split && m_store
			&& st_mask[retirement_event_tagging_pkg::SPLIT_BIT])); // see RULE_04

	// A retiring uop that could not carry a tag
	assign untagged_drop = (uop_retire && uop_untaggable)
		|| (replay_retire && replay_untaggable); // see RULE_05

	// Selector and enable registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upstream_sel <= retirement_event_tagging_pkg::REG_RESET;
			exec_sel <= retirement_event_tagging_pkg::REG_RESET;
			sample_enable_reg <= retirement_event_tagging_pkg::REG_RESET;
			replay_matrix_reg <= retirement_event_tagging_pkg::REG_RESET;
			load_store_selector_0 <= retirement_event_tagging_pkg::REG_RESET;
			load_store_selector_1 <= retirement_event_tagging_pkg::REG_RESET;
			mob_sel <= retirement_event_tagging_pkg::REG_RESET;
			replay_sel <= retirement_event_tagging_pkg::REG_RESET;
			qual_event <= retirement_event_tagging_pkg::EV_NONE;
			irq_mask <= retirement_event_tagging_pkg::ST_RESET;
		end else begin
			if (wr_hit(retirement_event_tagging_pkg::OFF_UPSTREAM)) begin
				upstream_sel <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_EXEC)) begin
				exec_sel <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_SAMPLE)) begin
				sample_enable_reg <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_MATRIX)) begin
				replay_matrix_reg <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_LS_SEL0)) begin
				load_store_selector_0 <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_LS_SEL1)) begin
				load_store_selector_1 <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_MOB_SEL)) begin
				mob_sel <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_REPLAY)) begin
				replay_sel <= reg_wdata;
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_QUAL)) begin
				qual_event <= retirement_event_tagging_pkg::qual_event_t'(
					reg_wdata[2:0]);
			end
			if (wr_hit(retirement_event_tagging_pkg::OFF_IRQ_MASK)) begin
				irq_mask <= reg_wdata[retirement_event_tagging_pkg::ST_W-1:0];
			end
		end
	end

	// Sticky status: a new event wins over a same-cycle clear
	always_comb begin
		next_status = status;
		if (wr_hit(retirement_event_tagging_pkg::OFF_STATUS)) begin
			next_status = status & ~reg_wdata[retirement_event_tagging_pkg::ST_W-1:0];
		end
		next_status[retirement_event_tagging_pkg::ST_EXEC] |= exec_hit;
		next_status[retirement_event_tagging_pkg::ST_REPLAY] |= replay_hit;
		next_status[retirement_event_tagging_pkg::ST_UNTAGGED] |= untagged_drop;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= retirement_event_tagging_pkg::ST_RESET;
		end else begin
			status <= next_status;
		end
	end

	// Interrupt from a flop fed by next_status, so it rises in the same cycle as the status
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & irq_mask);
		end
	end

	// Count pulses, registered so the counters see clean levels
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_count <= 1'b0;
			replay_count <= 1'b0;
		end else begin
			exec_count <= exec_hit; // see RULE_01
			replay_count <= replay_hit; // see RULE_03
		end
	end

	// Read data valid only in the cycle after the read strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= retirement_event_tagging_pkg::REG_RESET;
		end else if (reg_rd) begin
			case (reg_addr)
				retirement_event_tagging_pkg::OFF_UPSTREAM: reg_rdata <= upstream_sel;
				retirement_event_tagging_pkg::OFF_EXEC: reg_rdata <= exec_sel;
				retirement_event_tagging_pkg::OFF_SAMPLE:
					reg_rdata <= sample_enable_reg;
				retirement_event_tagging_pkg::OFF_MATRIX:
					reg_rdata <= replay_matrix_reg;
				retirement_event_tagging_pkg::OFF_LS_SEL0:
					reg_rdata <= load_store_selector_0;
				retirement_event_tagging_pkg::OFF_LS_SEL1:
					reg_rdata <= load_store_selector_1;
				retirement_event_tagging_pkg::OFF_MOB_SEL: reg_rdata <= mob_sel;
				retirement_event_tagging_pkg::OFF_REPLAY: reg_rdata <= replay_sel;
				retirement_event_tagging_pkg::OFF_QUAL:
					reg_rdata <= {qual_defined, qual_indep}; // see RULE_08
				retirement_event_tagging_pkg::OFF_STATUS:
					reg_rdata <= {29'h0000_0000, status};
				retirement_event_tagging_pkg::OFF_IRQ_MASK:
					reg_rdata <= {29'h0000_0000, irq_mask};
				default: reg_rdata <= retirement_event_tagging_pkg::REG_RESET;
			endcase
		end else begin
			reg_rdata <= retirement_event_tagging_pkg::REG_RESET;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_EXEC_TAGVAL: assert property ( // see RULE_01
		exec_count |-> $past(upstream_sel[
			retirement_event_tagging_pkg::TAGVAL_LSB +:
			retirement_event_tagging_pkg::TAGVAL_W])
			== retirement_event_tagging_pkg::TAG_VALUE_COUNTED
			&& $past(exec_mask[retirement_event_tagging_pkg::NONSPEC_TAG0_BIT])
			&& !$past(uop_speculative))
		else $error("execution count without tag value one");
	AST_EXEC_CAUSE: assert property ( // see RULE_01
		$rose(exec_count) |-> $past(uop_retire)
			&& $past(upstream_sel[retirement_event_tagging_pkg::TAG_EN_BIT]))
		else $error("execution count without tagged retirement");
	AST_REPLAY_COMMON: assert property ( // see RULE_03
		replay_count |->
			$past(sample_enable_reg[retirement_event_tagging_pkg::SE_COMMON_A])
			&& $past(sample_enable_reg[retirement_event_tagging_pkg::SE_COMMON_B])
			&& $past(rp_mask[retirement_event_tagging_pkg::NONSPEC_BIT]))
		else $error("replay count without common enables");
	AST_SPLIT_STORE: assert property ( // see RULE_04
		(replay_base && replay_split && replay_is_store && !replay_is_load
			&& sample_enable_reg[retirement_event_tagging_pkg::SE_SPLIT]
			&& m_store && st_mask[retirement_event_tagging_pkg::SPLIT_BIT])
			|=> replay_count)
		else $error("split store replay not counted");
	AST_UNTAGGED_EXEC: assert property ( // see RULE_05
		uop_untaggable && !replay_retire |=> !exec_count)
		else $error("untaggable uop counted");
	AST_UNTAGGED_REPLAY: assert property ( // see RULE_05
		replay_retire && replay_untaggable |=> !replay_count
			&& status[retirement_event_tagging_pkg::ST_UNTAGGED])
		else $error("untaggable replay counted or not flagged");
	AST_LATE_MISS: assert property ( // see RULE_06
		(replay_l2_late_miss && !replay_l2_fast_miss && !replay_l1_miss
			&& !replay_dtlb_miss && !replay_fwd_unaligned && !replay_split)
		|=> !replay_count)
		else $error("late second-level miss counted");
	AST_ORDER_BUF: assert property ( // see RULE_07
		(replay_base && m_load && replay_fwd_unaligned
			&& sample_enable_reg[retirement_event_tagging_pkg::SE_ORDER_BUF]
			&& mob_mask[retirement_event_tagging_pkg::PARTIAL_FWD_BIT]
			&& mob_mask[retirement_event_tagging_pkg::MISALIGNED_BIT])
		|=> replay_count)
		else $error("unaligned forward replay not counted");
	AST_QUAL_READ: assert property ( // see RULE_08
		(reg_rd && reg_addr == retirement_event_tagging_pkg::OFF_QUAL
			&& qual_event == retirement_event_tagging_pkg::EV_MEDIA64_UOP)
		|=> reg_rdata == 32'h8000_8000)
		else $error("thread-independent class misreported");

endmodule // retirement_event_tagging

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
	// Clock, reset and register port
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	// Pipeline side
	logic uop_retire = 1'b0;
	logic [6:0] uop_event_code = 7'h00;
	logic [15:0] uop_mask_hits = 16'h0000;
	logic uop_untaggable = 1'b0;
	logic uop_speculative = 1'b0;
	logic [9:0] rp_f = 10'h000;
	logic replay_retire = 1'b0;
	logic exec_count;
	logic replay_count;
	logic irq;
	int error_cnt = 0;
	int checked = 0;
	logic [31:0] qexp [8];

	always #12.5 core_clk = ~core_clk;

	retirement_event_tagging u_retirement_event_tagging (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .uop_retire(uop_retire),
		.uop_event_code(uop_event_code), .uop_mask_hits(uop_mask_hits),
		.uop_untaggable(uop_untaggable), .uop_speculative(uop_speculative),
		.replay_retire(replay_retire), .replay_is_load(rp_f[9]),
		.replay_is_store(rp_f[8]), .replay_untaggable(rp_f[7]),
		.replay_speculative(rp_f[6]), .replay_l1_miss(rp_f[5]),
		.replay_l2_fast_miss(rp_f[4]), .replay_l2_late_miss(rp_f[3]),
		.replay_dtlb_miss(rp_f[2]), .replay_fwd_unaligned(rp_f[1]),
		.replay_split(rp_f[0]), .exec_count(exec_count),
		.replay_count(replay_count), .irq(irq)
	);

	// Case equality so an unknown never passes
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One-cycle write; next access waits for a fresh edge
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, exp);
	endtask

	task automatic uop(input logic [6:0] c, input logic [15:0] h,
			input logic sp, un, ex);
		@(posedge core_clk);
		uop_retire <= 1'b1;
		uop_event_code <= c;
		uop_mask_hits <= h;
		uop_speculative <= sp;
		uop_untaggable <= un;
		@(posedge core_clk);
		uop_retire <= 1'b0;
		#1 chk("exec_count", exec_count, ex);
	endtask

	// f = load store untag spec l1 l2fast l2late dtlb fwd split
	task automatic rp(input logic [9:0] f, input logic ex);
		@(posedge core_clk);
		replay_retire <= 1'b1;
		rp_f <= f;
		@(posedge core_clk);
		replay_retire <= 1'b0;
		#1 chk("replay_count", replay_count, ex);
	endtask

	// Upstream selector: code, mask, tag value, tag enable
	function automatic logic [31:0] up(input logic [6:0] c,
			input logic [15:0] m, input logic [3:0] tv);
		return {c, m, tv, 1'b1, 4'h0};
	endfunction

	task automatic sc_reset();
		chk("irq", irq, 1'b0);
		rd(retirement_event_tagging_pkg::OFF_STATUS, 32'h0000_0000);
		wr(6'h2C, 32'hFFFF_FFFF);
		rd(6'h2C, 32'h0000_0000);
		rd(retirement_event_tagging_pkg::OFF_UPSTREAM, 32'h0000_0000);
	endtask

	task automatic sc_exec();
		wr(retirement_event_tagging_pkg::OFF_IRQ_MASK, 32'h0000_0001);
		wr(retirement_event_tagging_pkg::OFF_EXEC, 32'h0000_0200);
		wr(retirement_event_tagging_pkg::OFF_UPSTREAM, up(7'h05, 16'h8000, 4'h1));
		uop(7'h05, 16'h8000, 1'b0, 1'b0, 1'b1);
		chk("irq", irq, 1'b1);
		uop(7'h05, 16'h8000, 1'b0, 1'b0, 1'b1);
		uop(7'h06, 16'h8000, 1'b0, 1'b0, 1'b0);
		uop(7'h05, 16'h8000, 1'b1, 1'b0, 1'b0);
		rd(retirement_event_tagging_pkg::OFF_STATUS, 32'h0000_0001);
		wr(retirement_event_tagging_pkg::OFF_STATUS, 32'h0000_0001);
		#1 chk("irq", irq, 1'b0);
		// Wrong tag value, then the memory-moves port masks
		wr(retirement_event_tagging_pkg::OFF_UPSTREAM, up(7'h05, 16'h8000, 4'h2));
		uop(7'h05, 16'h8000, 1'b0, 1'b0, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_UPSTREAM, up(7'h2E, 16'h0018, 4'h1));
		uop(7'h2E, 16'h0008, 1'b0, 1'b0, 1'b1);
		uop(7'h2E, 16'h0010, 1'b0, 1'b0, 1'b1);
		uop(7'h2E, 16'h0010, 1'b0, 1'b1, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_EXEC, 32'h0000_0000);
		uop(7'h2E, 16'h0010, 1'b0, 1'b0, 1'b0);
		rd(retirement_event_tagging_pkg::OFF_STATUS, 32'h0000_0005);
		wr(retirement_event_tagging_pkg::OFF_STATUS, 32'h0000_0007);
	endtask

	task automatic sc_replay();
		wr(retirement_event_tagging_pkg::OFF_IRQ_MASK, 32'h0000_0000);
		wr(retirement_event_tagging_pkg::OFF_REPLAY, 32'h0000_0200);
		wr(retirement_event_tagging_pkg::OFF_MATRIX, 32'h0000_0003);
		wr(retirement_event_tagging_pkg::OFF_SAMPLE, 32'h0200_0003);
		rp(10'b10_00_100000, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_SAMPLE, 32'h0300_0003);
		rp(10'b10_00_100000, 1'b1);
		chk("irq", irq, 1'b0);
		rp(10'b10_00_010000, 1'b1);
		rp(10'b10_00_001000, 1'b0);
		rp(10'b10_01_100000, 1'b0);
		rp(10'b10_10_100000, 1'b0);
		// Data TLB misses count for loads and stores, each by its matrix bit
		wr(retirement_event_tagging_pkg::OFF_SAMPLE, 32'h0300_0004);
		rp(10'b10_00_000100, 1'b1);
		rp(10'b01_00_000100, 1'b1);
		wr(retirement_event_tagging_pkg::OFF_MATRIX, 32'h0000_0001);
		rp(10'b01_00_000100, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_MATRIX, 32'h0000_0003);
		// Order-buffer replay needs both forward mask bits
		wr(retirement_event_tagging_pkg::OFF_MOB_SEL, 32'h0000_6000);
		wr(retirement_event_tagging_pkg::OFF_SAMPLE, 32'h0300_0200);
		rp(10'b10_00_000010, 1'b1);
		rp(10'b10_00_000000, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_MOB_SEL, 32'h0000_2000);
		rp(10'b10_00_000010, 1'b0);
		// Split accesses through the two load/store selectors
		wr(retirement_event_tagging_pkg::OFF_SAMPLE, 32'h0300_0400);
		rp(10'b10_00_000001, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_LS_SEL1, 32'h0000_0400);
		rp(10'b10_00_000001, 1'b1);
		rp(10'b01_00_000001, 1'b0);
		wr(retirement_event_tagging_pkg::OFF_LS_SEL0, 32'h0000_0400);
		rp(10'b01_00_000001, 1'b1);
		wr(retirement_event_tagging_pkg::OFF_MATRIX, 32'h0000_0001);
		rp(10'b01_00_000001, 1'b0);
		rd(retirement_event_tagging_pkg::OFF_STATUS, 32'h0000_0006);
	endtask

	task automatic sc_qual();
		qexp = '{32'h0001_0000, 32'h3FEF_0000, 32'h0FFF_0000,
			32'h000C_0000, 32'h8000_8000, 32'h8000_8000,
			32'h8000_8000, 32'h0000_0000};
		for (int i = 0; i < 8; i++) begin
			wr(retirement_event_tagging_pkg::OFF_QUAL, 32'(i));
			rd(retirement_event_tagging_pkg::OFF_QUAL, qexp[i]);
		end
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		sc_reset();
		sc_exec();
		sc_replay();
		sc_qual();
		give_verdict();
	end
endmodule // testbench
